// *** pkg/warc_mem_if.sv ***
/*
 carrier between the control block and its readback memory.
 assumes the write side runs on the system clock, the read side on the
 configuration clock.
*/
`timescale 1ns/1ps
interface warc_mem_if;
   logic                         wrEn;
   logic [warc_pkg::ADDR_W-1:0]  wrAddr;
   logic [warc_pkg::DATA_W-1:0]  wrData;
   logic [warc_pkg::ADDR_W-1:0]  rdAddr;
   logic [warc_pkg::DATA_W-1:0]  rdData;
   modport store  (input wrEn, wrAddr, wrData, rdAddr, output rdData);
   modport client (output wrEn, wrAddr, wrData, rdAddr, input rdData);
endinterface

// *** pkg/warc_pkg.sv ***
/*
 wakeup and readback control: shared constants, state types and the
 start-up sequence table.
 assumes nothing beyond a SystemVerilog compiler.
*/
package warc_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 64;
   // command byte layout
   localparam int CMD_OP_MSB = 7;
   localparam int CMD_OP_LSB = 6;
   localparam int CMD_ADDR_MSB = 5;
   localparam logic [1:0] OP_READ_MEM = 2'h2;
   localparam logic [1:0] OP_READ_STATUS = 2'h3;
   // busy cycles: bus turnaround after a command, refetch after a byte
   localparam logic [2:0] TURN_CYCLES = 3'h3;
   localparam logic [2:0] FETCH_CYCLES = 3'h2;
   localparam logic [2:0] COUNT_LAST = 3'h1;
   // start-up sequence selection
   localparam logic [4:0] SEQ_MIN = 5'h01;
   localparam logic [4:0] SEQ_MAX_SELF = 5'h19;
   localparam logic [4:0] SEQ_DEF_SELF = 5'h15;
   localparam logic [4:0] SEQ_MAX_EXT = 5'h07;
   localparam logic [4:0] SEQ_DEF_EXT = 5'h04;
   // start-up clock selection
   localparam logic [1:0] CLKSEL_CFG = 2'h0;
   localparam logic [1:0] CLKSEL_SCAN = 2'h1;
   localparam logic [1:0] CLKSEL_USER = 2'h2;
   localparam logic [1:0] CLKSEL_AUTO = 2'h3;
   // phase fields inside a table entry, two bits each
   localparam int PH_DONE = 6;
   localparam int PH_OUT_EN = 4;
   localparam int PH_WR_DIS = 2;
   localparam int PH_SET_RST = 0;
   localparam logic [2:0] PHASE_BASE = 3'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ARMED = 3'b001,
      ST_T0    = 3'b010,
      ST_T1    = 3'b011,
      ST_T2    = 3'b100,
      ST_T3    = 3'b101,
      ST_AWAKE = 3'b110
   } warc_phase_e;

   typedef enum logic [1:0] {
      LK_IDLE  = 2'b00,
      LK_FETCH = 2'b01,
      LK_READY = 2'b10
   } warc_link_e;

   // phase of {completion, output enable, write disable, set/reset}
   function automatic logic [7:0] warcSeqPhases(input logic [4:0] seq);
      unique case (seq)
         5'h01: return 8'h15;  5'h02: return 8'h2a;  5'h03: return 8'h3f;
         5'h04: return 8'h1a;  5'h05: return 8'h1f;  5'h06: return 8'h1b;
         5'h07: return 8'h1e;  5'h08: return 8'h6a;  5'h09: return 8'h7f;
         5'h0a: return 8'h7a;  5'h0b: return 8'h6f;  5'h0c: return 8'hbf;
         5'h0d: return 8'h95;  5'h0e: return 8'h9f;  5'h0f: return 8'h97;
         5'h10: return 8'hb7;  5'h11: return 8'hb5;  5'h12: return 8'h9d;
         5'h13: return 8'hea;  5'h14: return 8'hd5;  5'h15: return 8'hda;
         5'h16: return 8'hd6;  5'h17: return 8'he6;  5'h18: return 8'he5;
         5'h19: return 8'hd9;
         default: return 8'hda;
      endcase
   endfunction
endpackage

// *** rtl/warc_readback_mem.sv ***
/*
 configuration memory image for readback, one write and one read port.
 assumes writes and reads of the same word are not simultaneous.
*/
`timescale 1ns/1ps
module warc_readback_mem (
   // clocks
   input  wire logic   wrClk,
   input  wire logic   rdClk,
   // ports
   warc_mem_if.store   mem
);
   logic [warc_pkg::DATA_W-1:0] store [warc_pkg::MEM_DEPTH];

   always_ff @(posedge wrClk) begin
      if (mem.wrEn) begin
         store[mem.wrAddr] <= mem.wrData;
      end
   end

   // registered read: data follow the address by one read clock
   always_ff @(posedge rdClk) begin
      mem.rdData <= store[mem.rdAddr];
   end
endmodule

// *** rtl/warc_sync.sv ***
/*
 two flip-flop synchroniser for levels.
 assumes each bit is a level that stays put for several destination cycles.
*/
`timescale 1ns/1ps
module warc_sync #(
   parameter int WIDTH = 1
) (
   // clock
   input  wire logic             clk,
   // data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // no reset: the stages only ever hold a copy of d
   always_ff @(posedge clk) begin
      meta <= d;
      q    <= meta;
   end
endmodule

// *** rtl/warc_wakeup_readback.sv ***
/*
 wake-up sequencer and slave parallel readback port.
 assumes clk is the system clock, configurationClock is driven by the host,
 and the host changes its port pins away from configurationClock rising edges.
*/
//
// Behaviour
// - without external wait, start on internal completion
// - with external wait, hold until pin high
// - sample completion pin on start-up clock
// - four phases release four global signals
// - sequence 21: enable, write/reset, then pin
// - default 21 of 1-25, or 4 of 1-7
// - chaining overflow forces external wait on
// - start-up clock: configuration, scan or user
// - busy high while working, selects ignored
// - busy low when ready; drive only when selected
// - selects and strobe latched on clock edge
// - busy held through slow bus turnaround
// - byte moves when selected and not busy
// - transparent readback needs pin retention on
// - readback during configuration via this port
// - retention reserves configuration pins, default on
// - busy low means ready next edge
// - completion pin open-drain by default
`timescale 1ns/1ps
module warc_wakeup_readback (
   // system
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // options
   input  wire logic       externalCompletionWait,
   input  wire logic       overflowChainActive,
   input  wire logic       completionPinOpenDrain,
   input  wire logic [4:0] startupSequence,
   input  wire logic [1:0] startupClockSelect,
   input  wire logic       boundaryScanConfig,
   input  wire logic       configPinRetain,
   // start-up clocks and trigger
   input  wire logic       boundaryScanClock,
   input  wire logic       userStartupClock,
   input  wire logic       loadComplete,
   // completion pin
   input  wire logic       completionPinIn,
   output logic            completionPinOut,
   output logic            completionPinOe,
   // global controls
   output logic            globalOutputEnable,
   output logic            globalWriteDisable,
   output logic            globalSetReset,
   output logic            deviceAwake,
   output logic            configPinsReserved,
   // configuration memory load
   input  wire logic       loadWrite,
   input  wire logic [5:0] loadAddr,
   input  wire logic [7:0] loadData,
   // slave parallel port
   input  wire logic       configurationClock,
   input  wire logic       selectLow,
   input  wire logic       secondSelectLow,
   input  wire logic       writeStrobeLow,
   input  wire logic [7:0] busDataIn,
   output logic            busy,
   output logic [7:0]      busDataOut,
   output logic            busDataOe
);
   ////////////////////////////////////////////////////////////////////////
   // start-up clock selection and pin sampling
   logic [3:0] pinSync;
   logic [2:0] clkPrev;
   logic [1:0] clkSelEff;
   logic       stepEdge;
   logic       extWaitEff;
   logic       odEff;
   logic [4:0] seqEff;

   warc_sync #(.WIDTH(4)) u_pinSync (
      .clk (clk),
      .d   ({completionPinIn, userStartupClock, boundaryScanClock, configurationClock}),
      .q   (pinSync)
   );

   function automatic logic released(input warc_pkg::warc_phase_e st, input logic [1:0] ph);
      return st >= (warc_pkg::PHASE_BASE + {1'b0, ph});
   endfunction

   always_comb begin
      extWaitEff = externalCompletionWait | overflowChainActive;
      odEff      = completionPinOpenDrain | extWaitEff;
      clkSelEff  = startupClockSelect;
      // automatic choice follows the configuration port in use
      if (startupClockSelect == warc_pkg::CLKSEL_AUTO) begin
         clkSelEff = boundaryScanConfig ? warc_pkg::CLKSEL_SCAN : warc_pkg::CLKSEL_CFG;
      end
      unique case (clkSelEff)
         warc_pkg::CLKSEL_SCAN: stepEdge = pinSync[1] & ~clkPrev[1];
         warc_pkg::CLKSEL_USER: stepEdge = pinSync[2] & ~clkPrev[2];
         default:               stepEdge = pinSync[0] & ~clkPrev[0];
      endcase
      // out of range or zero falls back to the mode default
      if (extWaitEff) begin
         seqEff = (startupSequence < warc_pkg::SEQ_MIN || startupSequence > warc_pkg::SEQ_MAX_EXT)
                  ? warc_pkg::SEQ_DEF_EXT : startupSequence;
      end else begin
         seqEff = (startupSequence < warc_pkg::SEQ_MIN || startupSequence > warc_pkg::SEQ_MAX_SELF)
                  ? warc_pkg::SEQ_DEF_SELF : startupSequence;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start-up sequencer
   warc_pkg::warc_phase_e phase, next_phase;
   logic [7:0] seqPhases, next_seqPhases;
   logic       extDoneSeen, next_extDoneSeen;
   logic       trigger;
   logic       next_outEn, next_wrDis, next_setRst, next_pinRel, next_pinOut, next_pinOe;
   logic       readbackAllowed, next_readbackAllowed;
   logic [7:0] statusByte, next_statusByte;

   always_comb begin
      next_phase       = phase;
      next_seqPhases   = seqPhases;
      next_extDoneSeen = extDoneSeen;
      // the pin is only looked at on a start-up clock edge
      if (stepEdge) begin
         next_extDoneSeen = pinSync[3];
      end
      // external wait also needs our own load finished
      trigger = extWaitEff ? (loadComplete & extDoneSeen) : loadComplete;
      unique case (phase)
         warc_pkg::ST_IDLE: begin
            next_seqPhases = warc_pkg::warcSeqPhases(seqEff);
            if (trigger) begin
               next_phase = warc_pkg::ST_ARMED;
            end
         end
         warc_pkg::ST_ARMED: if (stepEdge) next_phase = warc_pkg::ST_T0;
         warc_pkg::ST_T0:    if (stepEdge) next_phase = warc_pkg::ST_T1;
         warc_pkg::ST_T1:    if (stepEdge) next_phase = warc_pkg::ST_T2;
         warc_pkg::ST_T2:    if (stepEdge) next_phase = warc_pkg::ST_T3;
         warc_pkg::ST_T3:    if (stepEdge) next_phase = warc_pkg::ST_AWAKE;
         warc_pkg::ST_AWAKE: next_phase = warc_pkg::ST_AWAKE;
         default:            next_phase = warc_pkg::ST_IDLE;
      endcase
      // each global signal lets go at its own phase
      next_outEn  = released(next_phase, next_seqPhases[warc_pkg::PH_OUT_EN +: 2]);
      next_wrDis  = !released(next_phase, next_seqPhases[warc_pkg::PH_WR_DIS +: 2]);
      next_setRst = !released(next_phase, next_seqPhases[warc_pkg::PH_SET_RST +: 2]);
      // under external wait our pull is dropped once loaded so others decide
      next_pinRel = released(next_phase, next_seqPhases[warc_pkg::PH_DONE +: 2])
                    | (extWaitEff & loadComplete);
      next_pinOut = next_pinRel;
      next_pinOe  = !(next_pinRel && odEff);
      // user mode readback only with the port pins kept
      next_readbackAllowed = (next_phase != warc_pkg::ST_AWAKE) | configPinRetain;
      next_statusByte = {next_phase, extWaitEff, loadComplete, next_pinRel,
                         next_extDoneSeen, next_readbackAllowed};
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase              <= warc_pkg::ST_IDLE;
         seqPhases          <= 8'h00;
         extDoneSeen        <= 1'b0;
         clkPrev            <= 3'h0;
         globalOutputEnable <= 1'b0;
         globalWriteDisable <= 1'b1;
         globalSetReset     <= 1'b1;
         completionPinOut   <= 1'b0;
         completionPinOe    <= 1'b1;
         deviceAwake        <= 1'b0;
         configPinsReserved <= 1'b1;
         readbackAllowed    <= 1'b1;
         statusByte         <= 8'h00;
      end else begin
         phase              <= next_phase;
         seqPhases          <= next_seqPhases;
         extDoneSeen        <= next_extDoneSeen;
         clkPrev            <= pinSync[2:0];
         globalOutputEnable <= next_outEn;
         globalWriteDisable <= next_wrDis;
         globalSetReset     <= next_setRst;
         completionPinOut   <= next_pinOut;
         completionPinOe    <= next_pinOe;
         deviceAwake        <= next_phase == warc_pkg::ST_AWAKE;
         configPinsReserved <= configPinRetain;
         readbackAllowed    <= next_readbackAllowed;
         statusByte         <= next_statusByte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crossing into the configuration clock domain
   // status bits cross one by one: a status read taken mid-change may mix
   // old and new bits, accepted since the byte only reports progress
   logic [9:0] linkSync;
   logic       linkRst;
   logic       allowSync;
   logic [7:0] statusSync;

   warc_sync #(.WIDTH(10)) u_linkSync (
      .clk (configurationClock),
      .d   ({statusByte, readbackAllowed, sys_rst}),
      .q   (linkSync)
   );

   assign linkRst    = linkSync[0];
   assign allowSync  = linkSync[1];
   assign statusSync = linkSync[9:2];

   warc_mem_if memBus ();

   warc_readback_mem u_mem (
      .wrClk (clk),
      .rdClk (configurationClock),
      .mem   (memBus.store)
   );

   assign memBus.wrEn   = loadWrite;
   assign memBus.wrAddr = loadAddr;
   assign memBus.wrData = loadData;

   ////////////////////////////////////////////////////////////////////////
   // slave parallel readback port
   warc_pkg::warc_link_e linkState, next_linkState;
   logic       bothSelQ, wrLowQ;
   logic [7:0] dinQ;
   logic [2:0] turnCount, next_turnCount;
   logic [5:0] rdAddr, next_rdAddr;
   logic       readStatus, next_readStatus;
   logic       next_busy, next_dataOe;
   logic [7:0] next_dataOut;
   logic       cmdTaken, byteTaken, bothSelNow;
   logic [1:0] cmdOp;

   assign memBus.rdAddr = rdAddr;

   always_comb begin
      bothSelNow = !selectLow && !secondSelectLow;
      cmdOp      = dinQ[warc_pkg::CMD_OP_MSB:warc_pkg::CMD_OP_LSB];
      // command decoded from the pins latched at the previous edge
      // a new command also ends a transfer left waiting in READY, so it is not lost
      cmdTaken   = (linkState == warc_pkg::LK_IDLE || linkState == warc_pkg::LK_READY) && bothSelQ && wrLowQ
                   && allowSync && (cmdOp == warc_pkg::OP_READ_MEM || cmdOp == warc_pkg::OP_READ_STATUS);
      byteTaken  = linkState == warc_pkg::LK_READY && busDataOe && bothSelNow && !busy;
      next_linkState  = linkState;
      next_turnCount  = turnCount;
      next_rdAddr     = rdAddr;
      next_readStatus = readStatus;
      next_busy       = busy;
      next_dataOut    = busDataOut;
      next_dataOe     = 1'b0;
      unique case (linkState)
         warc_pkg::LK_IDLE: next_busy = 1'b0;
         // selects play no part while the data are fetched
         warc_pkg::LK_FETCH: begin
            if (turnCount == warc_pkg::COUNT_LAST) begin
               next_linkState = warc_pkg::LK_READY;
               next_busy      = 1'b0;
               next_dataOut   = readStatus ? statusSync : memBus.rdData;
            end else begin
               next_turnCount = turnCount - 3'h1;
            end
         end
         warc_pkg::LK_READY: begin
            if (wrLowQ) begin
               next_linkState = warc_pkg::LK_IDLE;
            end else if (byteTaken) begin
               next_linkState = warc_pkg::LK_FETCH;
               next_busy      = 1'b1;
               next_turnCount = warc_pkg::FETCH_CYCLES;
               next_rdAddr    = rdAddr + 6'h01;
            end else begin
               // never drive while the host still holds a command on the bus
               next_dataOe = bothSelNow && writeStrobeLow;
            end
         end
         default: next_linkState = warc_pkg::LK_IDLE;
      endcase
      if (cmdTaken) begin
         next_linkState  = warc_pkg::LK_FETCH;
         next_busy       = 1'b1;
         next_turnCount  = warc_pkg::TURN_CYCLES;
         next_rdAddr     = dinQ[warc_pkg::CMD_ADDR_MSB:0];
         next_readStatus = cmdOp == warc_pkg::OP_READ_STATUS;
      end
   end

   always_ff @(posedge configurationClock) begin
      if (linkRst) begin
         linkState  <= warc_pkg::LK_IDLE;
         bothSelQ   <= 1'b0;
         wrLowQ     <= 1'b0;
         dinQ       <= 8'h00;
         turnCount  <= 3'h0;
         rdAddr     <= 6'h00;
         readStatus <= 1'b0;
         busy       <= 1'b0;
         busDataOut <= 8'h00;
         busDataOe  <= 1'b0;
      end else begin
         linkState  <= next_linkState;
         bothSelQ   <= bothSelNow;
         wrLowQ     <= !writeStrobeLow;
         dinQ       <= busDataIn;
         turnCount  <= next_turnCount;
         rdAddr     <= next_rdAddr;
         readStatus <= next_readStatus;
         busy       <= next_busy;
         busDataOut <= next_dataOut;
         busDataOe  <= next_dataOe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_internal_start: assert property (@(posedge clk) disable iff (sys_rst)
      phase == warc_pkg::ST_IDLE && !extWaitEff && loadComplete |=> phase == warc_pkg::ST_ARMED)
      else $error("internal completion did not start the sequence");
   a_external_hold: assert property (@(posedge clk) disable iff (sys_rst)
      phase == warc_pkg::ST_IDLE && extWaitEff && !extDoneSeen |=> phase == warc_pkg::ST_IDLE)
      else $error("start-up left idle without the external pin");
   a_one_phase_step: assert property (@(posedge clk) disable iff (sys_rst)
      phase != warc_pkg::ST_IDLE && !stepEdge |=> $stable(phase))
      else $error("phase moved without a start-up clock edge");
   a_default_order: assert property (@(posedge clk) disable iff (sys_rst)
      phase == warc_pkg::ST_T1 && seqPhases == warc_pkg::warcSeqPhases(warc_pkg::SEQ_DEF_SELF) && !extWaitEff
      |-> globalOutputEnable && globalWriteDisable && globalSetReset && !completionPinOut)
      else $error("default sequence released out of order");
   a_seq_in_range: assert property (@(posedge clk) disable iff (sys_rst)
      extWaitEff |-> seqEff >= warc_pkg::SEQ_MIN && seqEff <= warc_pkg::SEQ_MAX_EXT)
      else $error("sequence outside the external wait range");
   a_open_drain: assert property (@(posedge clk) disable iff (sys_rst)
      completionPinOut && $past(odEff) |-> !completionPinOe)
      else $error("released completion pin still driven");
   a_turnaround_busy: assert property (@(posedge configurationClock) disable iff (linkRst)
      cmdTaken |=> busy [*3] ##1 !busy)
      else $error("busy not held through turnaround");
   a_fetch_busy: assert property (@(posedge configurationClock) disable iff (linkRst)
      linkState == warc_pkg::LK_FETCH |-> busy)
      else $error("busy low while fetching");
   a_drive_when_selected: assert property (@(posedge configurationClock) disable iff (linkRst)
      busDataOe |-> !busy && linkState == warc_pkg::LK_READY && $past(bothSelNow))
      else $error("bus driven without both selects");
endmodule

// *** sim/tb.sv ***
/*
 self-checking bench for the wake-up sequencer and readback port.
 assumes warc_host_model stands in for the parallel port host.
*/
`timescale 1ns/1ps
module tb;
   logic       clk = 1'b0, sys_rst = 1'b1, extWait = 1'b0, overflow = 1'b0, scanCfg = 1'b0;
   logic       scanClk = 1'b0, userClk = 1'b0, loadDone = 1'b0, pinIn = 1'b0, loadWrite = 1'b0;
   logic       od = 1'b1, retain = 1'b1;
   logic [4:0] seqSel = 5'h00;
   logic [1:0] clkSel = 2'h2;
   logic [5:0] loadAddr = 6'h00;
   logic [7:0] loadData = 8'h00;
   logic [7:0] busIn, busOut;
   logic [7:0] got [4];
   logic       pinOut, pinOe, global_output_enable, gWd, global_set_reset, awake, reserved, cfgClk, sel, sel2, strobe, busy, busOe;
   int         fails = 0, checks_done = 0, cycles = 0, busyCnt;
   warc_wakeup_readback uut (.clk(clk), .sys_rst(sys_rst), .externalCompletionWait(extWait),
      .overflowChainActive(overflow), .completionPinOpenDrain(od), .startupSequence(seqSel),
      .startupClockSelect(clkSel), .boundaryScanConfig(scanCfg), .configPinRetain(retain),
      .boundaryScanClock(scanClk), .userStartupClock(userClk), .loadComplete(loadDone),
      .completionPinIn(pinIn), .completionPinOut(pinOut), .completionPinOe(pinOe),
      .globalOutputEnable(global_output_enable), .globalWriteDisable(gWd), .globalSetReset(global_set_reset), .deviceAwake(awake),
      .configPinsReserved(reserved), .loadWrite(loadWrite), .loadAddr(loadAddr), .loadData(loadData),
      .configurationClock(cfgClk), .selectLow(sel), .secondSelectLow(sel2), .writeStrobeLow(strobe),
      .busDataIn(busIn), .busy(busy), .busDataOut(busOut), .busDataOe(busOe));
   warc_host_model host (.configurationClock(cfgClk), .selectLow(sel), .secondSelectLow(sel2),
      .writeStrobeLow(strobe), .busDataIn(busIn), .busy(busy), .busDataOut(busOut), .busDataOe(busOe));
   ////////////////////////////////////////////////////////////////////////////////
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // reset is held long enough for the link side's two-flop reset path
   task automatic do_reset();
      sys_rst = 1'b1;
      loadDone = 1'b0;
      pinIn = 1'b0;
      host.clkOn = 1'b1;
      repeat (24) @(posedge clk);
      #1 sys_rst = 1'b0;
      repeat (24) @(posedge clk);
      #1 host.clkOn = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [8:0] exp_wake(int k, int pd, int pg, int pw, int ps);
      return {3'h0, k > pd, !(k > pd), k > pg, !(k > pw), !(k > ps), k > 4};
   endfunction
   task automatic edge_clk(input logic scan);
      if (scan) scanClk = 1'b1;
      else userClk = 1'b1;
      repeat (6) @(posedge clk);
      #1 scanClk = 1'b0;
      userClk = 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask
   task automatic run_wake(input logic scan, input int pd, pg, pw, ps);
      for (int k = 1; k <= 5; k++) begin
         edge_clk(scan);
         chk({3'h0, pinOut, pinOe, global_output_enable, gWd, global_set_reset, awake}, exp_wake(k, pd, pg, pw, ps));
      end
   endtask
   task automatic s_reset();
      do_reset();
      chk({pinOut, pinOe, global_output_enable, gWd, global_set_reset, awake, reserved, busy, busOe}, 9'h0b4);
   endtask
   task automatic s_self();
      do_reset();
      clkSel = 2'h2;
      seqSel = 5'h00;
      retain = 1'b0;
      loadDone = 1'b1;
      repeat (4) @(posedge clk);
      #1 chk({3'h0, pinOut, pinOe, global_output_enable, gWd, global_set_reset, awake}, exp_wake(0, 3, 1, 2, 2));
      run_wake(1'b0, 3, 1, 2, 2);
      // awake without pin retention: the read command must be ignored
      host.read_burst(8'h80, 1, got, busyCnt);
      chk({reserved, 8'(busyCnt)}, 9'h000);
      retain = 1'b1;
   endtask
   task automatic s_ext();
      do_reset();
      overflow = 1'b1;
      od = 1'b0;
      clkSel = 2'h3;
      scanCfg = 1'b1;
      seqSel = 5'h19;
      loadDone = 1'b1;
      edge_clk(1'b1);
      edge_clk(1'b1);
      chk({4'h0, pinOe, global_output_enable, gWd, global_set_reset, awake} & 9'h00f, exp_wake(0, 0, 1, 2, 2) & 9'h00f);
      pinIn = 1'b1;
      edge_clk(1'b1);
      run_wake(1'b1, 0, 1, 2, 2);
      pinIn = 1'b0;
      od = 1'b1;
      clkSel = 2'h2;
      overflow = 1'b0;
   endtask
   task automatic s_read();
      do_reset();
      for (int i = 0; i < 3; i++) begin
         loadWrite = 1'b1;
         loadAddr = 6'h3e + 6'(i);
         loadData = 8'h5a ^ 8'(i * 8'h33);
         @(posedge clk);
         #1;
      end
      loadWrite = 1'b0;
      host.read_burst(8'hbe, 3, got, busyCnt);
      chk(9'(busyCnt), 9'h003);
      for (int i = 0; i < 3; i++) chk({1'b0, got[i]}, {1'b0, 8'h5a ^ 8'(i * 8'h33)});
      // status while armed: {phase 1, no wait, loaded, pin held, no pin seen, allowed}
      loadDone = 1'b1;
      repeat (4) @(posedge clk);
      #1 host.read_burst(8'hc0, 1, got, busyCnt);
      chk({1'b0, got[0]}, 9'h029);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      s_reset();
      s_self();
      s_ext();
      s_read();
      print_verdict();
   end
endmodule

// *** sim/warc_host_model.sv ***
/*
 host model for the slave parallel readback port.
 assumes the device samples the port pins on configurationClock rising edges.
*/
`timescale 1ns/1ps
module warc_host_model (
   // port pins
   output logic       configurationClock,
   output logic       selectLow,
   output logic       secondSelectLow,
   output logic       writeStrobeLow,
   output logic [7:0] busDataIn,
   // device answers
   input  wire logic       busy,
   input  wire logic [7:0] busDataOut,
   input  wire logic       busDataOe
);
   // set at declaration so the bench may start the clock at time zero
   logic clkOn = 1'b0;
   initial begin
      configurationClock = 1'b0;
      selectLow = 1'b1;
      secondSelectLow = 1'b1;
      writeStrobeLow = 1'b1;
      busDataIn = 8'h00;
   end
   // the clock parks low between frames; odd offset keeps it unrelated to clk
   initial begin
      #5;
      forever #16 if (clkOn || configurationClock) configurationClock = ~configurationClock;
   end
   task automatic read_burst(input logic [7:0] cmd, input int n, output logic [7:0] got [4], output int busyCnt);
      int k;
      k = 0;
      busyCnt = 0;
      clkOn = 1'b1;
      @(posedge configurationClock) #2;
      selectLow = 1'b0;
      secondSelectLow = 1'b0;
      writeStrobeLow = 1'b0;
      busDataIn = cmd;
      @(posedge configurationClock) #2;
      writeStrobeLow = 1'b1;
      busDataIn = ~cmd;
      for (int e = 0; e < 60 && k < n; e++) begin
         @(posedge configurationClock);
         if (busy === 1'b1 && k == 0) busyCnt++;
         // one pause cycle after every byte, so each byte crosses a select edge
         if (busy === 1'b0 && busDataOe === 1'b1 && selectLow == 1'b0) begin
            got[k] = busDataOut;
            k++;
            #2 selectLow = 1'b1;
         end else begin
            #2 selectLow = 1'b0;
         end
         busDataIn = ~busDataIn;
      end
      @(posedge configurationClock) #2;
      selectLow = 1'b1;
      secondSelectLow = 1'b1;
      @(posedge configurationClock) #2 clkOn = 1'b0;
   endtask
endmodule
